// >>> logic/cmb_pkg.sv
// Shared constants for the mode and bit-timing configuration block
package cmb_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	////////////////////////////////////////////////////////////////////////
	// Byte offsets of the word registers
	localparam logic [ADDR_W-1:0] OFF_RST_EN = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PRESC = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TIMING = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
	localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Field positions in bus order: printed bit n sits at bus bit 31-n
	localparam int unsigned EN_BIT = 1;
	localparam int unsigned SOFT_RST_BIT = 0;
	localparam int unsigned LOOP_BIT = 1;
	localparam int unsigned SLEEP_BIT = 0;
	localparam int unsigned PRESC_LSB = 0;
	localparam int unsigned PRESC_W = 8;
	localparam int unsigned SEG1_LSB = 0;
	localparam int unsigned SEG1_W = 4;
	localparam int unsigned SEG2_LSB = 4;
	localparam int unsigned SEG2_W = 3;
	localparam int unsigned JW_LSB = 7;
	localparam int unsigned JW_W = 2;
	localparam int unsigned STAT_CFG_BIT = 0;
	localparam int unsigned STAT_LOOP_BIT = 1;
	localparam int unsigned STAT_SLEEP_BIT = 2;
	localparam int unsigned STAT_NORM_BIT = 3;

	////////////////////////////////////////////////////////////////////////
	// Bus levels and timing
	localparam logic RECESSIVE = 1'b1;
	localparam logic DOMINANT = 1'b0;
	localparam int unsigned IDLE_BITS = 11;
	localparam int unsigned REC_W = 4;
	localparam logic [REC_W-1:0] IDLE_LAST = 4'(IDLE_BITS - 1);
	localparam int unsigned QCNT_W = 5;
endpackage

// >>> logic/cmb_bt_if.sv
// Settings and sample strobe between the config core and the bit timer
interface cmb_bt_if;
	logic run;
	logic [cmb_pkg::PRESC_W-1:0] presc;
	logic [cmb_pkg::SEG1_W-1:0] seg1;
	logic [cmb_pkg::SEG2_W-1:0] seg2;
	logic [cmb_pkg::JW_W-1:0] jw;
	logic rx;
	logic smp;
	logic bit_val;
	modport cfg (output run, presc, seg1, seg2, jw, rx, input smp, bit_val);
	modport tmr (input run, presc, seg1, seg2, jw, rx, output smp, bit_val);
endinterface

// >>> logic/cmb_bit_timer.sv
// Quantum prescaler and bit-segment sequencer with resynchronisation
module cmb_bit_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Settings in, sample out
	cmb_bt_if.tmr bt
);
	typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_SEG2} cmb_phase_t;

	cmb_phase_t ph_q;
	logic [cmb_pkg::PRESC_W-1:0] pcnt_q;
	logic [cmb_pkg::QCNT_W-1:0] qcnt_q;
	logic [cmb_pkg::QCNT_W-1:0] lim_q;
	logic [cmb_pkg::QCNT_W-1:0] jump;
	logic [cmb_pkg::QCNT_W-1:0] left;
	logic [cmb_pkg::QCNT_W-1:0] qnext;
	logic tick_q;
	logic prev_q;
	logic rs_q;
	logic smp_q;
	logic bit_q;
	logic edge_s;

	assign jump = cmb_pkg::QCNT_W'(bt.jw) + 1'b1;
	assign qnext = qcnt_q + 1'b1;
	assign left = lim_q - qcnt_q;
	// One resync per bit, only on a recessive to dominant edge
	assign edge_s = tick_q && prev_q == cmb_pkg::RECESSIVE && bt.rx == cmb_pkg::DOMINANT && !rs_q;
	assign bt.smp = smp_q;
	assign bt.bit_val = bit_q;

	////////////////////////////////////////////////////////////////////////
	// Quantum tick every presc+1 clocks
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (!bt.run || pcnt_q == bt.presc) begin
			pcnt_q <= '0;
			tick_q <= bt.run;
		end else begin
			pcnt_q <= pcnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= cmb_pkg::RECESSIVE;
		end else if (tick_q) begin
			prev_q <= bt.rx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync, segment one, segment two
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ph_q <= PH_SYNC;
			qcnt_q <= '0;
			lim_q <= '0;
			rs_q <= 1'b0;
			smp_q <= 1'b0;
			bit_q <= cmb_pkg::RECESSIVE;
		end else begin
			smp_q <= 1'b0;
			if (!bt.run) begin
				ph_q <= PH_SYNC;
				qcnt_q <= '0;
				rs_q <= 1'b0;
			end else if (tick_q) begin
				case (ph_q)
					PH_SYNC: begin
						ph_q <= PH_SEG1;
						qcnt_q <= '0;
						lim_q <= cmb_pkg::QCNT_W'(bt.seg1);
						rs_q <= edge_s;
					end
					PH_SEG1: begin
						if (edge_s) begin
							// Late edge: stretch segment one by at most the jump width
							lim_q <= cmb_pkg::QCNT_W'(bt.seg1) + ((qnext < jump) ? qnext : jump);
							rs_q <= 1'b1;
							qcnt_q <= qnext;
						end else if (qcnt_q >= lim_q) begin
							ph_q <= PH_SEG2;
							qcnt_q <= '0;
							lim_q <= cmb_pkg::QCNT_W'(bt.seg2);
							smp_q <= 1'b1;
							bit_q <= bt.rx;
						end else begin
							qcnt_q <= qnext;
						end
					end
					PH_SEG2: begin
						if (edge_s && left < jump) begin
							// Early edge close to the end: it becomes the next sync quantum
							ph_q <= PH_SEG1;
							qcnt_q <= '0;
							lim_q <= cmb_pkg::QCNT_W'(bt.seg1);
							rs_q <= 1'b0;
						end else if (edge_s) begin
							lim_q <= lim_q - jump;
							rs_q <= 1'b1;
							qcnt_q <= qnext;
						end else if (qcnt_q >= lim_q) begin
							ph_q <= PH_SYNC;
							qcnt_q <= '0;
							rs_q <= 1'b0;
						end else begin
							qcnt_q <= qnext;
						end
					end
					default: begin
						ph_q <= PH_SYNC;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_tick_gap;
		(tick_q && bt.run && bt.presc != '0) |=> !tick_q;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("quantum ticks too close");

	property p_smp_point;
		smp_q |-> ph_q == PH_SEG2 && qcnt_q == '0 && lim_q == cmb_pkg::QCNT_W'(bt.seg2);
	endproperty
	a_smp_point: assert property (p_smp_point) else $error("sample not at segment boundary");

	property p_jump_cap;
		ph_q == PH_SEG1 |-> lim_q <= cmb_pkg::QCNT_W'(bt.seg1) + jump;
	endproperty
	a_jump_cap: assert property (p_jump_cap) else $error("segment one stretched past jump width");
endmodule

// >>> logic/cmb_config.sv
// Mode control and bit-timing configuration registers of the bus controller
// Overview of operation
// - Writing the reset/enable register with enable zero enters configuration mode.
// - Configuration mode drives recessive and neither sends nor receives.
// - After power-up enable and soft reset are zero, configuration flag one.
// - Prescaler and bit timing accept writes only while enable is zero.
// - Once enabled, wait for 11 recessive bits, then report the chosen mode.
// - Enable at bit 30, soft reset at 31; enable picks mode or configuration.
// - Soft reset clears all configuration registers; it always reads back zero.
// - Mode bits zero means normal; sleep bit selects sleep, loop bit loop-back.
// - Loop-back and sleep both set: loop-back alone is used.
// - Mode register holds loop-back at bit 30, sleep at 31, reset zero.
// - Loop-back select is writable only while enable is zero.
// - Waking from sleep clears the sleep select bit in hardware.
// - Prescaler field bits 24-31; quantum clock is clock divided by value+1.
// - Timing register: jump width 23-24, segment two 25-27, segment one 28-31.
// - Each timing field counts one more quantum than programmed.
// - Segment one is propagation plus phase one; segment two is phase two.
// - Registers are 32 bits, bit 0 the most significant.
// - Reserved bits read as zero.
module cmb_config (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Register port, byte address of aligned words
	input wire logic [cmb_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [cmb_pkg::DATA_W-1:0] reg_wdata,
	output logic [cmb_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Bus line through the transceiver
	input wire logic can_rx,
	output logic can_tx,
	// Protocol engine side
	input wire logic eng_tx_bit,
	output logic eng_smp,
	output logic eng_bit,
	// Operating mode
	output logic mode_cfg,
	output logic mode_normal,
	output logic mode_loop,
	output logic mode_sleep
);
	typedef enum logic [2:0] {ST_CONFIG, ST_WAIT, ST_NORMAL, ST_LOOP, ST_SLEEP} cmb_mode_t;

	cmb_mode_t st_q;
	cmb_mode_t st_d;
	logic en_q;
	logic loop_q;
	logic slp_q;
	logic [cmb_pkg::PRESC_W-1:0] presc_q;
	logic [cmb_pkg::SEG1_W-1:0] seg1_q;
	logic [cmb_pkg::SEG2_W-1:0] seg2_q;
	logic [cmb_pkg::JW_W-1:0] jw_q;
	logic rx_meta_q;
	logic rx_sync_q;
	logic [cmb_pkg::REC_W-1:0] rec_q;
	logic can_tx_q;
	logic smp_q;
	logic bit_q;
	logic cfg_q;
	logic norm_q;
	logic lpm_q;
	logic slm_q;
	logic [cmb_pkg::DATA_W-1:0] rdata_q;
	logic [cmb_pkg::DATA_W-1:0] rd_word;
	logic rvalid_q;
	logic w_rst;
	logic w_mode;
	logic w_presc;
	logic w_tim;
	logic soft_rst;
	logic idle_done;
	logic wake;

	cmb_bt_if bt();

	cmb_bit_timer u_timer (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.bt(bt.tmr)
	);

	function automatic logic wr_hit(input logic we, input logic [cmb_pkg::ADDR_W-1:0] a,
			input logic [cmb_pkg::ADDR_W-1:0] off);
		return we && a == off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write decode
	assign w_rst = wr_hit(reg_wr_en, reg_addr, cmb_pkg::OFF_RST_EN);
	assign w_mode = wr_hit(reg_wr_en, reg_addr, cmb_pkg::OFF_MODE);
	assign w_presc = wr_hit(reg_wr_en, reg_addr, cmb_pkg::OFF_PRESC);
	assign w_tim = wr_hit(reg_wr_en, reg_addr, cmb_pkg::OFF_TIMING);
	assign soft_rst = w_rst && reg_wdata[cmb_pkg::SOFT_RST_BIT];

	////////////////////////////////////////////////////////////////////////
	// Reset/enable register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 1'b0;
		end else if (soft_rst) begin
			en_q <= 1'b0;
		end else if (w_rst) begin
			en_q <= reg_wdata[cmb_pkg::EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode select register
	assign wake = st_q == ST_SLEEP && bt.smp && bt.bit_val == cmb_pkg::DOMINANT;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			loop_q <= 1'b0;
			slp_q <= 1'b0;
		end else if (soft_rst) begin
			loop_q <= 1'b0;
			slp_q <= 1'b0;
		end else if (w_mode) begin
			// A software write wins over the wake-up clear in the same cycle
			slp_q <= reg_wdata[cmb_pkg::SLEEP_BIT];
			if (!en_q) begin
				loop_q <= reg_wdata[cmb_pkg::LOOP_BIT];
			end
		end else if (wake) begin
			slp_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler and bit timing, locked while enabled
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			presc_q <= '0;
		end else if (soft_rst) begin
			presc_q <= '0;
		end else if (w_presc && !en_q) begin
			presc_q <= reg_wdata[cmb_pkg::PRESC_LSB +: cmb_pkg::PRESC_W];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			seg1_q <= '0;
			seg2_q <= '0;
			jw_q <= '0;
		end else if (soft_rst) begin
			seg1_q <= '0;
			seg2_q <= '0;
			jw_q <= '0;
		end else if (w_tim && !en_q) begin
			seg1_q <= reg_wdata[cmb_pkg::SEG1_LSB +: cmb_pkg::SEG1_W];
			seg2_q <= reg_wdata[cmb_pkg::SEG2_LSB +: cmb_pkg::SEG2_W];
			jw_q <= reg_wdata[cmb_pkg::JW_LSB +: cmb_pkg::JW_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus receive path; loop-back feeds the engine's own bits back
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_meta_q <= cmb_pkg::RECESSIVE;
			rx_sync_q <= cmb_pkg::RECESSIVE;
		end else begin
			rx_meta_q <= can_rx;
			rx_sync_q <= rx_meta_q;
		end
	end

	assign bt.run = en_q;
	assign bt.presc = presc_q;
	assign bt.seg1 = seg1_q;
	assign bt.seg2 = seg2_q;
	assign bt.jw = jw_q;
	assign bt.rx = (st_q == ST_LOOP) ? eng_tx_bit : rx_sync_q;

	////////////////////////////////////////////////////////////////////////
	// Bus idle detection before leaving configuration
	assign idle_done = bt.smp && bt.bit_val == cmb_pkg::RECESSIVE && rec_q == cmb_pkg::IDLE_LAST;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rec_q <= '0;
		end else if (st_q != ST_WAIT) begin
			rec_q <= '0;
		end else if (bt.smp) begin
			// Any dominant bit restarts the count
			rec_q <= (bt.bit_val == cmb_pkg::RECESSIVE) ? rec_q + 1'b1 : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operating mode
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_CONFIG: begin
				if (en_q) begin
					st_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (idle_done) begin
					if (loop_q) begin
						st_d = ST_LOOP;
					end else if (slp_q) begin
						st_d = ST_SLEEP;
					end else begin
						st_d = ST_NORMAL;
					end
				end
			end
			ST_NORMAL: begin
				if (slp_q) begin
					st_d = ST_SLEEP;
				end
			end
			ST_LOOP: begin
				st_d = ST_LOOP;
			end
			ST_SLEEP: begin
				if (!slp_q) begin
					st_d = ST_NORMAL;
				end
			end
			default: begin
				st_d = ST_CONFIG;
			end
		endcase
		if (!en_q) begin
			st_d = ST_CONFIG;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_CONFIG;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus drive and engine strobes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			can_tx_q <= cmb_pkg::RECESSIVE;
			smp_q <= 1'b0;
			bit_q <= cmb_pkg::RECESSIVE;
		end else begin
			// Loop-back and sleep keep the line recessive too
			can_tx_q <= (st_q == ST_NORMAL) ? eng_tx_bit : cmb_pkg::RECESSIVE;
			smp_q <= bt.smp && (st_q inside {ST_NORMAL, ST_LOOP});
			bit_q <= bt.bit_val;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= 1'b1;
			norm_q <= 1'b0;
			lpm_q <= 1'b0;
			slm_q <= 1'b0;
		end else begin
			cfg_q <= st_q inside {ST_CONFIG, ST_WAIT};
			norm_q <= st_q == ST_NORMAL;
			lpm_q <= st_q == ST_LOOP;
			slm_q <= st_q == ST_SLEEP;
		end
	end

	assign can_tx = can_tx_q;
	assign eng_smp = smp_q;
	assign eng_bit = bit_q;
	assign mode_cfg = cfg_q;
	assign mode_normal = norm_q;
	assign mode_loop = lpm_q;
	assign mode_sleep = slm_q;

	////////////////////////////////////////////////////////////////////////
	// Read path, one cycle latency
	always_comb begin
		rd_word = cmb_pkg::RST_WORD;
		case (reg_addr)
			cmb_pkg::OFF_RST_EN: begin
				rd_word[cmb_pkg::EN_BIT] = en_q;
			end
			cmb_pkg::OFF_MODE: begin
				rd_word[cmb_pkg::LOOP_BIT] = loop_q;
				rd_word[cmb_pkg::SLEEP_BIT] = slp_q;
			end
			cmb_pkg::OFF_PRESC: begin
				rd_word[cmb_pkg::PRESC_LSB +: cmb_pkg::PRESC_W] = presc_q;
			end
			cmb_pkg::OFF_TIMING: begin
				rd_word[cmb_pkg::SEG1_LSB +: cmb_pkg::SEG1_W] = seg1_q;
				rd_word[cmb_pkg::SEG2_LSB +: cmb_pkg::SEG2_W] = seg2_q;
				rd_word[cmb_pkg::JW_LSB +: cmb_pkg::JW_W] = jw_q;
			end
			cmb_pkg::OFF_STATUS: begin
				rd_word[cmb_pkg::STAT_CFG_BIT] = cfg_q;
				rd_word[cmb_pkg::STAT_LOOP_BIT] = lpm_q;
				rd_word[cmb_pkg::STAT_SLEEP_BIT] = slm_q;
				rd_word[cmb_pkg::STAT_NORM_BIT] = norm_q;
			end
			default: begin
				rd_word = cmb_pkg::RST_WORD;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= cmb_pkg::RST_WORD;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_en;
			if (reg_rd_en) begin
				rdata_q <= rd_word;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_dis_wr;
		w_rst && !reg_wdata[cmb_pkg::EN_BIT];
	endsequence
	sequence s_idle_seen;
		st_q == ST_WAIT && idle_done && en_q;
	endsequence

	// Enable lands one edge after the write, the state one edge later
	property p_dis;
		s_dis_wr |=> ##1 st_q == ST_CONFIG ##1 (mode_cfg && can_tx == cmb_pkg::RECESSIVE);
	endproperty
	a_dis: assert property (p_dis) else $error("disable write did not enter configuration");

	property p_quiet;
		st_q inside {ST_CONFIG, ST_WAIT} |=> can_tx == cmb_pkg::RECESSIVE && !eng_smp;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus activity in configuration");

	property p_cfg_flag;
		!en_q [*3] |-> mode_cfg && !mode_normal;
	endproperty
	a_cfg_flag: assert property (p_cfg_flag) else $error("configuration flag low while disabled");

	property p_lock;
		(w_presc || w_tim) && en_q |=> presc_q == $past(presc_q) && seg1_q == $past(seg1_q)
			&& seg2_q == $past(seg2_q) && jw_q == $past(jw_q);
	endproperty
	a_lock: assert property (p_lock) else $error("timing changed while enabled");

	property p_idle_exit;
		s_idle_seen |=> !(st_q inside {ST_CONFIG, ST_WAIT}) ##1 !mode_cfg;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("no mode entry after idle bits");

	property p_soft;
		soft_rst |=> !en_q && !loop_q && !slp_q && presc_q == '0 && seg1_q == '0 && seg2_q == '0 && jw_q == '0;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset left a register set");

	property p_soft_rd;
		reg_rd_en && reg_addr == cmb_pkg::OFF_RST_EN |=> reg_rvalid && !reg_rdata[cmb_pkg::SOFT_RST_BIT];
	endproperty
	a_soft_rd: assert property (p_soft_rd) else $error("soft reset bit read as one");

	property p_prio;
		st_q == ST_WAIT && idle_done && en_q && loop_q |=> st_q == ST_LOOP ##1 (mode_loop && !mode_sleep);
	endproperty
	a_prio: assert property (p_prio) else $error("loop-back did not take priority");

	property p_lb_lock;
		w_mode && en_q |=> loop_q == $past(loop_q);
	endproperty
	a_lb_lock: assert property (p_lb_lock) else $error("loop-back select changed while enabled");

	property p_wake;
		wake && en_q && !w_mode && !soft_rst |=> !slp_q ##1 st_q inside {ST_NORMAL, ST_CONFIG};
	endproperty
	a_wake: assert property (p_wake) else $error("sleep bit not cleared on wake-up");

	property p_normal_tx;
		st_q == ST_NORMAL |=> can_tx == $past(eng_tx_bit);
	endproperty
	a_normal_tx: assert property (p_normal_tx) else $error("normal mode not driving engine bits");
endmodule

// >>> verification/cmb_bus_model.sv
// Bus line model standing behind the transceiver
module cmb_bus_model (
	// Controller side
	input wire logic can_tx,
	output logic can_rx,
	// Bench side
	input wire logic dom_req
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wired-AND: termination pulls the idle bus recessive, any node wins with dominant
	assign can_rx = can_tx & ~dom_req;
endmodule

// >>> verification/tb.sv
// Self-checking testbench for the mode and bit-timing configuration block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [cmb_pkg::ADDR_W-1:0] reg_addr = 8'h00;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [cmb_pkg::DATA_W-1:0] reg_wdata = 32'h0000_0000;
	logic [cmb_pkg::DATA_W-1:0] reg_rdata;
	logic reg_rvalid;
	logic can_rx;
	logic can_tx;
	logic eng_tx_bit = 1'b1;
	logic eng_smp;
	logic eng_bit;
	logic mode_cfg;
	logic mode_normal;
	logic mode_loop;
	logic mode_sleep;
	logic dom_req = 1'b0;
	logic [3:0] mvec;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	int n;

	assign mvec = {mode_normal, mode_sleep, mode_loop, mode_cfg};
	always #4 clk_sys = ~clk_sys;

	cmb_config dut (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.can_rx(can_rx),
		.can_tx(can_tx),
		.eng_tx_bit(eng_tx_bit),
		.eng_smp(eng_smp),
		.eng_bit(eng_bit),
		.mode_cfg(mode_cfg),
		.mode_normal(mode_normal),
		.mode_loop(mode_loop),
		.mode_sleep(mode_sleep)
	);

	cmb_bus_model bus (
		.can_tx(can_tx),
		.can_rx(can_rx),
		.dom_req(dom_req)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk_sys);
		reg_wr_en = 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk_sys);
		reg_rd_en = 1'b0;
		// Valid stands for the one cycle after the read edge only
		chk({31'h0, reg_rvalid}, 32'h1);
		chk(reg_rdata, exp);
	endtask

	// Bounded so a missing strobe ends with n at 200 instead of a hang
	task automatic wait_smp(output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			#1;
			c++;
		end while (eng_smp !== 1'b1 && c < 200);
	endtask

	task automatic wait_mode(input int i);
		int c;
		c = 0;
		while (mvec[i] !== 1'b1 && c < 800) begin
			@(posedge clk_sys);
			#1;
			c++;
		end
		chk(32'(mvec), 32'(1 << i));
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({30'h0, mode_cfg, can_tx}, 32'h3);
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h0c, 32'h0);
		rchk(8'h18, 32'h1);
		rchk(8'h10, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_config();
		wr(8'h08, 32'hffff_ff01);
		wr(8'h0c, 32'hffff_fe12);
		rchk(8'h08, 32'h1);
		rchk(8'h0c, 32'h12);
		$display("config test done");
	endtask

	task automatic t_enable();
		@(negedge clk_sys);
		dom_req = 1'b1;
		wr(8'h00, 32'hffff_fffe);
		repeat (200) @(posedge clk_sys);
		#1;
		chk({31'h0, mode_cfg}, 32'h1);
		@(negedge clk_sys);
		dom_req = 1'b0;
		wait_mode(3);
		rchk(8'h18, 32'h8);
		rchk(8'h00, 32'h2);
		wait_smp(n);
		wait_smp(n);
		chk(32'(n), 32'd12);
		chk({30'h0, eng_bit, can_tx}, 32'h3);
		$display("enable test done");
	endtask

	task automatic t_locked();
		wr(8'h08, 32'h55);
		wr(8'h0c, 32'hff);
		wr(8'h04, 32'h2);
		rchk(8'h08, 32'h1);
		rchk(8'h0c, 32'h12);
		rchk(8'h04, 32'h0);
		chk(32'(mvec), 32'h8);
		$display("locked test done");
	endtask

	task automatic t_disable();
		@(negedge clk_sys);
		eng_tx_bit = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({31'h0, can_tx}, 32'h0);
		wr(8'h00, 32'h0);
		wait_mode(0);
		chk({31'h0, can_tx}, 32'h1);
		// Let any strobe already in the output pipe drain first
		repeat (4) @(posedge clk_sys);
		wait_smp(n);
		chk(32'(n), 32'd200);
		@(negedge clk_sys);
		eng_tx_bit = 1'b1;
		$display("disable test done");
	endtask

	task automatic t_soft();
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h5);
		rchk(8'h04, 32'h2);
		wr(8'h00, 32'h3);
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h0c, 32'h0);
		chk(32'(mvec), 32'h1);
		$display("soft reset test done");
	endtask

	task automatic t_loop();
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h2);
		wait_mode(1);
		wait_smp(n);
		wait_smp(n);
		chk(32'(n), 32'd3);
		@(negedge clk_sys);
		eng_tx_bit = 1'b0;
		wait_smp(n);
		wait_smp(n);
		chk({30'h0, eng_bit, can_tx}, 32'h1);
		@(negedge clk_sys);
		eng_tx_bit = 1'b1;
		wr(8'h00, 32'h0);
		wait_mode(0);
		$display("loop-back test done");
	endtask

	task automatic t_sleep();
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h2);
		wait_mode(2);
		rchk(8'h04, 32'h1);
		@(negedge clk_sys);
		dom_req = 1'b1;
		wait_mode(3);
		@(negedge clk_sys);
		dom_req = 1'b0;
		rchk(8'h04, 32'h0);
		$display("sleep test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		reset_n = 1'b1;
		t_reset();
		t_config();
		t_enable();
		t_locked();
		t_disable();
		t_soft();
		t_loop();
		t_sleep();
		end_of_test();
	end
endmodule
